// *** psr_defs.svh ***
// Offsets, field positions, reset values and timing for the path select registers
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

`define PSR_OFS_PATH_SEL 8'h00
`define PSR_OFS_TX_CTRL 8'h10
`define PSR_OFS_SEED_B6 8'ha0
`define PSR_OFS_SEED_B7 8'ha1
`define PSR_OFS_TP_CTRL0 8'ha2
`define PSR_OFS_TP_CTRL1 8'ha3
`define PSR_OFS_ERR_LO 8'ha4
`define PSR_OFS_ERR_HI 8'ha5
`define PSR_OFS_PMA_STAT 8'hc6
`define PSR_OFS_PMA_CTRL 8'hc7
`define PSR_OFS_LOOPBACK 8'he0
`define PSR_OFS_ST_CTRL0 8'he1
`define PSR_OFS_ST_CTRL1 8'he2
`define PSR_OFS_C1_B0 8'he3
`define PSR_OFS_C1_B1 8'he4
`define PSR_OFS_C1_MSB 8'he5
`define PSR_OFS_C2_B0 8'he6
`define PSR_OFS_C2_B1 8'he7
`define PSR_OFS_C2_MSB 8'he8
`define PSR_OFS_ST_STAT0 8'he9
`define PSR_OFS_ST_STAT1 8'hea
`define PSR_OFS_PHY_STAT 8'hfe

`define PSR_POS_RX_SEL 5
`define PSR_POS_RX_OVRD 4
`define PSR_POS_TX_SEL 1
`define PSR_POS_TX_OVRD 0
`define PSR_POS_PMFIFO_DIS 7
`define PSR_POS_BOND_MASK 6
`define PSR_POS_WIDE_BUS 5

`define PSR_MASK_PATH_SEL 8'h77
`define PSR_MASK_PHY_W1C 8'h0f
`define PSR_RST_BYTE 8'h00
`define PSR_RST_MODE 2'h0
`define PSR_SYNC_STAGES 3

`endif

// *** psr_pkg.sv ***
// Types shared by the path select register bank
package psr_pkg;

  typedef enum logic [1:0] {
    PSR_MODE_8B10B = 2'b00,
    PSR_MODE_64B66B = 2'b01,
    PSR_MODE_RSVD = 2'b10,
    PSR_MODE_PMA = 2'b11
  } psr_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
    logic [7:0] wdata;
  } psr_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } psr_cfg_rsp_t;

  typedef struct packed {
    psr_mode_t rxMode;
    psr_mode_t txMode;
    logic pmFifoDisable;
    logic bondMask;
    logic wideBus;
    logic bondMember;
  } psr_path_cfg_t;

endpackage

// *** psr_path_select_regs.sv ***
// Per-channel path select and control register bank on the local config bus
//
// Contract
// (R1) Rx source 11 raw, 01 64b66b, 00 8b10b
// (R2) Rx override picks field, else external select
// (R3) Tx source bits 2:1 decode likewise
// (R4) Tx override bit 0 picks field, else external
// (R5) Tx override uses the Tx source field
// (R6) Bit 7 set disables Tx phase FIFO
// (R7) Bond mask bit excludes channel from group
// (R8) Wide bus bit: 20-bit set, 10-bit clear
// (R9) Wide bus bit ignored in 64b66b mode
// (R10) Path select register resets to zero
// (R11) Error count read-only, low byte first
// (R12) Selftest constants three bytes, LSB lowest
// (R13) PHY status mixes read-only and W1C bits
`timescale 1ns/1ns
`include "psr_defs.svh"

module psr_path_select_regs import psr_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire psr_cfg_req_t cfgReq,
  output psr_cfg_rsp_t cfgRsp,
  input wire logic [1:0] externalCodingSelect,
  input wire logic [1:0] txGroupingKind,
  input wire logic [15:0] testPatternCtrl,
  input wire logic [15:0] testErrorCount,
  input wire logic [7:0] pmaStatus,
  input wire logic [15:0] selftestStatus,
  input wire logic [3:0] phyEvent,
  input wire logic [3:0] phyLevel,
  output psr_path_cfg_t pathCfg,
  output logic [15:0] testSeedB,
  output logic [7:0] pmaControl,
  output logic [7:0] loopbackControl,
  output logic [15:0] selftestControl,
  output logic [23:0] selftestConst1,
  output logic [23:0] selftestConst2
);

  localparam int NRW = 14;
  localparam logic [7:0] RW_OFS [NRW] = '{
    `PSR_OFS_PATH_SEL, `PSR_OFS_TX_CTRL, `PSR_OFS_SEED_B6, `PSR_OFS_SEED_B7,
    `PSR_OFS_PMA_CTRL, `PSR_OFS_LOOPBACK, `PSR_OFS_ST_CTRL0, `PSR_OFS_ST_CTRL1,
    `PSR_OFS_C1_B0, `PSR_OFS_C1_B1, `PSR_OFS_C1_MSB,
    `PSR_OFS_C2_B0, `PSR_OFS_C2_B1, `PSR_OFS_C2_MSB
  };
  // Reserved bits of the path select register never store
  localparam logic [7:0] RW_MASK [NRW] = '{
    `PSR_MASK_PATH_SEL, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
  };

  logic [7:0] rwByte_q [NRW];
  logic [NRW-1:0] rwHit;
  logic [3:0] phySticky_q;
  logic [1:0] extSync1_q;
  logic [1:0] extSync2_q;
  logic [1:0] extSync3_q;
  psr_mode_t extMode_q;
  psr_mode_t rxMode_d;
  psr_mode_t txMode_d;
  psr_cfg_rsp_t cfgRsp_q;
  psr_path_cfg_t pathCfg_q;
  logic [7:0] rdata_d;
  logic wrStrobe;
  logic phyW1c;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire logic [7:0] pathSel = rwByte_q[0];
  wire logic [7:0] txCtrl = rwByte_q[1];
  wire psr_mode_t rxField = psr_mode_t'(pathSel[`PSR_POS_RX_SEL +: 2]);
  wire psr_mode_t txField = psr_mode_t'(pathSel[`PSR_POS_TX_SEL +: 2]);

  assign wrStrobe = cfgReq.valid & cfgReq.write;
  assign phyW1c = wrStrobe & (cfgReq.offset == `PSR_OFS_PHY_STAT);

  // One byte register per writable offset
  genvar gi;
  generate
    for (gi = 0; gi < NRW; gi++) begin : gRw
      assign rwHit[gi] = wrStrobe & (cfgReq.offset == RW_OFS[gi]);
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          rwByte_q[gi] <= `PSR_RST_BYTE; // R10
        end else if (rwHit[gi]) begin
          rwByte_q[gi] <= cfgReq.wdata & RW_MASK[gi];
        end
      end
    end
  endgenerate

  // Sticky PHY events; an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phySticky_q <= 4'h0;
    end else begin
      phySticky_q <= (phySticky_q & ~({4{phyW1c}} & cfgReq.wdata[3:0])) | phyEvent; // R13
    end
  end

  // The external select is a pin; accept it only once two stages agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extSync1_q <= `PSR_RST_MODE;
      extSync2_q <= `PSR_RST_MODE;
      extSync3_q <= `PSR_RST_MODE;
      extMode_q <= PSR_MODE_8B10B;
    end else begin
      extSync1_q <= externalCodingSelect;
      extSync2_q <= extSync1_q;
      extSync3_q <= extSync2_q;
      if (extSync2_q == extSync3_q) begin
        extMode_q <= psr_mode_t'(extSync3_q);
      end
    end
  end

  // A reserved code holds the mode in force rather than guess a path
  always_comb begin
    rxMode_d = pathCfg_q.rxMode;
    txMode_d = pathCfg_q.txMode;
    if (pathSel[`PSR_POS_RX_OVRD]) begin
      if (rxField != PSR_MODE_RSVD) begin
        rxMode_d = rxField; // R1 R2
      end
    end else if (extMode_q != PSR_MODE_RSVD) begin
      rxMode_d = extMode_q; // R2
    end
    if (pathSel[`PSR_POS_TX_OVRD]) begin
      if (txField != PSR_MODE_RSVD) begin
        txMode_d = txField; // R3 R4 R5
      end
    end else if (extMode_q != PSR_MODE_RSVD) begin
      txMode_d = extMode_q; // R4
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pathCfg_q <= '0;
    end else begin
      pathCfg_q.rxMode <= rxMode_d;
      pathCfg_q.txMode <= txMode_d;
      pathCfg_q.pmFifoDisable <= txCtrl[`PSR_POS_PMFIFO_DIS]; // R6
      pathCfg_q.bondMask <= txCtrl[`PSR_POS_BOND_MASK]; // R7
      pathCfg_q.bondMember <= ~txCtrl[`PSR_POS_BOND_MASK] & (|txGroupingKind); // R7
      pathCfg_q.wideBus <= txCtrl[`PSR_POS_WIDE_BUS] & (txMode_d != PSR_MODE_64B66B); // R8 R9
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    for (int i = 0; i < NRW; i++) begin
      if (cfgReq.offset == RW_OFS[i]) begin
        rdata_d = rwByte_q[i];
      end
    end
    case (cfgReq.offset)
      `PSR_OFS_TP_CTRL0: rdata_d = testPatternCtrl[7:0];
      `PSR_OFS_TP_CTRL1: rdata_d = testPatternCtrl[15:8];
      `PSR_OFS_ERR_LO: rdata_d = testErrorCount[7:0]; // R11
      `PSR_OFS_ERR_HI: rdata_d = testErrorCount[15:8]; // R11
      `PSR_OFS_PMA_STAT: rdata_d = pmaStatus;
      `PSR_OFS_ST_STAT0: rdata_d = selftestStatus[7:0];
      `PSR_OFS_ST_STAT1: rdata_d = selftestStatus[15:8];
      `PSR_OFS_PHY_STAT: rdata_d = {phyLevel, phySticky_q}; // R13
      default: ;
    endcase
  end

  // Read data one cycle after the request; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgRsp_q <= '0;
    end else begin
      cfgRsp_q.valid <= cfgReq.valid & ~cfgReq.write;
      cfgRsp_q.rdata <= (cfgReq.valid & ~cfgReq.write) ? rdata_d : 8'h00;
    end
  end

  assign cfgRsp = cfgRsp_q;
  assign pathCfg = pathCfg_q;
  assign testSeedB = {rwByte_q[3], rwByte_q[2]};
  assign pmaControl = rwByte_q[4];
  assign loopbackControl = rwByte_q[5];
  assign selftestControl = {rwByte_q[7], rwByte_q[6]};
  assign selftestConst1 = {rwByte_q[10], rwByte_q[9], rwByte_q[8]}; // R12
  assign selftestConst2 = {rwByte_q[13], rwByte_q[12], rwByte_q[11]}; // R12

  rx_field_mode_a: assert property ( // R1
    pathSel[`PSR_POS_RX_OVRD] && rxField != PSR_MODE_RSVD
      |=> pathCfg_q.rxMode == $past(rxField))
    else $error("Rx mode does not follow its field");

  rx_ext_mode_a: assert property ( // R2
    !pathSel[`PSR_POS_RX_OVRD] && extMode_q != PSR_MODE_RSVD
      |=> pathCfg_q.rxMode == $past(extMode_q))
    else $error("Rx mode does not follow external select");

  tx_field_mode_a: assert property ( // R3
    pathSel[`PSR_POS_TX_OVRD] && txField != PSR_MODE_RSVD
      |=> pathCfg_q.txMode == $past(txField))
    else $error("Tx mode does not follow its field");

  tx_ext_mode_a: assert property ( // R4
    !pathSel[`PSR_POS_TX_OVRD] && extMode_q != PSR_MODE_RSVD
      |=> pathCfg_q.txMode == $past(extMode_q))
    else $error("Tx mode does not follow external select");

  tx_own_field_a: assert property ( // R5
    pathSel[`PSR_POS_TX_OVRD] && txField == PSR_MODE_RSVD
      |=> $stable(pathCfg_q.txMode))
    else $error("Tx mode moved on reserved Tx field");

  pm_fifo_a: assert property ( // R6
    rwHit[1] ##1 1'b1 |=> pathCfg_q.pmFifoDisable == $past(cfgReq.wdata[7], 2))
    else $error("Phase FIFO disable not applied");

  bond_mask_a: assert property ( // R7
    pathCfg_q.bondMask |-> !pathCfg_q.bondMember)
    else $error("Masked channel still in bond group");

  wide_bus_a: assert property ( // R9
    pathCfg_q.txMode == PSR_MODE_64B66B |-> !pathCfg_q.wideBus)
    else $error("Wide bus set in 64b66b mode");

  wide_set_a: assert property ( // R8
    txCtrl[`PSR_POS_WIDE_BUS] && txMode_d != PSR_MODE_64B66B |=> pathCfg_q.wideBus)
    else $error("Wide bus not selected");

  err_count_a: assert property ( // R11
    cfgReq.valid && !cfgReq.write && cfgReq.offset == `PSR_OFS_ERR_LO
      |=> cfgRsp_q.valid && cfgRsp_q.rdata == $past(testErrorCount[7:0]))
    else $error("Error count low byte misread");

  const_msb_a: assert property ( // R12
    rwHit[10] |=> selftestConst1[23:16] == $past(cfgReq.wdata))
    else $error("Constant MSB not at highest offset");

  event_set_a: assert property ( // R13
    phyEvent[0] |=> phySticky_q[0] ##1 phySticky_q[0] || $past(phyW1c))
    else $error("PHY event lost");

  w1c_clear_a: assert property ( // R13
    phyW1c && cfgReq.wdata[0] && !phyEvent[0] |=> !phySticky_q[0])
    else $error("PHY status bit not cleared");

  path_reset_a: assert property ( // R10
    disable iff (1'b0) $past(sys_rst) |-> pathSel == 8'h00)
    else $error("Path select not zero after reset");

endmodule

// *** psr_cfg_host.sv ***
// Fabric-side model driving the local config bus
`timescale 1ns/1ns
module psr_cfg_host import psr_pkg::*; (
  input wire logic clk,
  output psr_cfg_req_t cfgReq,
  input wire psr_cfg_rsp_t cfgRsp
);
  initial cfgReq = '0;

  // Request held until the taking edge; once released, valid and write drop to zero and offset and data show inverted values
  task automatic access(input logic wr, input logic [7:0] ofs, input logic [7:0] wd,
      output psr_cfg_rsp_t rsp);
    @(posedge clk);
    #1 cfgReq = '{1'b1, wr, ofs, wd};
    @(posedge clk);
    #1 cfgReq = '{1'b0, 1'b0, ~ofs, ~wd};
    rsp = cfgRsp;
  endtask
endmodule

// *** pcs_path_select_regs_bench.sv ***
// Self-checking bench for the path select register bank
`timescale 1ns/1ns
`include "psr_defs.svh"
module pcs_path_select_regs_bench import psr_pkg::*;;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  psr_cfg_req_t cfgReq;
  psr_cfg_rsp_t cfgRsp;
  psr_path_cfg_t pathCfg;
  logic [1:0] extSel = 2'b00;
  logic [1:0] grpKind = 2'b00;
  logic [15:0] errCnt = 16'h0000;
  logic [3:0] phyEvent = 4'h0;
  logic [3:0] phyLevel = 4'h0;
  logic [23:0] c1;
  logic [23:0] c2;
  logic [15:0] seedB;
  logic [7:0] pmaCtl;
  logic [7:0] loopCtl;
  logic [15:0] stCtl;
  logic [15:0] roVal = 16'h0000;
  logic [1:0] rxPrev = 2'b00;
  logic [1:0] txPrev = 2'b00;
  logic [7:0] rwOfs [9] = '{`PSR_OFS_SEED_B6, `PSR_OFS_SEED_B7, `PSR_OFS_PMA_CTRL,
    `PSR_OFS_LOOPBACK, `PSR_OFS_ST_CTRL0, `PSR_OFS_ST_CTRL1, `PSR_OFS_C2_B0,
    `PSR_OFS_C2_B1, `PSR_OFS_C2_MSB};
  logic [7:0] rwVal [9];
  logic [15:0] lfsrQ = 16'hbad3;
  logic [7:0] selB = 8'h00;
  logic [7:0] txB = 8'h00;
  logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};
  logic [23:0] v;
  int fails = 0;
  int testsRun = 0;

  always #20 clk = ~clk;

  psr_path_select_regs u_dut (.clk(clk), .sys_rst(sysRst), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
    .externalCodingSelect(extSel), .txGroupingKind(grpKind), .testPatternCtrl(roVal),
    .testErrorCount(errCnt), .pmaStatus(roVal[15:8]), .selftestStatus(~roVal),
    .phyEvent(phyEvent), .phyLevel(phyLevel), .pathCfg(pathCfg), .testSeedB(seedB),
    .pmaControl(pmaCtl), .loopbackControl(loopCtl), .selftestControl(stCtl),
    .selftestConst1(c1), .selftestConst2(c2));

  psr_cfg_host u_host (.clk(clk), .cfgReq(cfgReq), .cfgRsp(cfgRsp));

  function logic [15:0] rnd();
    lfsrQ = {lfsrQ[14:0], lfsrQ[15] ^ lfsrQ[13] ^ lfsrQ[12] ^ lfsrQ[10]};
    return lfsrQ;
  endfunction

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    psr_cfg_rsp_t r;
    u_host.access(1'b0, ofs, 8'h00, r);
    chk("read", {15'h0, 1'b1, exp}, {15'h0, r});
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    psr_cfg_rsp_t r;
    u_host.access(1'b1, ofs, d, r);
  endtask

  // Model of the resolved modes and Tx controls
  task automatic chkPath();
    logic [1:0] rxm;
    logic [1:0] txm;
    logic wide;
    rxm = selB[4] ? selB[6:5] : extSel;
    txm = selB[0] ? selB[2:1] : extSel;
    // Reserved code keeps the mode already in force
    if (rxm == 2'b10) rxm = rxPrev;
    if (txm == 2'b10) txm = txPrev;
    rxPrev = rxm;
    txPrev = txm;
    wide = txB[5] && txm != 2'b01;
    chk("path", {16'h0, rxm, txm, txB[7:6], wide, !txB[6] && grpKind != 2'b00},
      {16'h0, pathCfg});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    #1 sysRst = 1'b0;
    chkPath();
    rd(`PSR_OFS_PATH_SEL, 8'h00);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      #1 extSel = codes[rnd() % 3];
      grpKind = 2'(rnd());
      // Reserved bits thrown in on purpose; they must not store
      selB = {1'b0, codes[(i / 3) % 3], 2'b00, codes[i % 3], 1'b0} | (8'(rnd()) & 8'h99);
      txB = 8'(rnd()) | ((i % 2) ? 8'h20 : 8'h00);
      wr(`PSR_OFS_PATH_SEL, selB);
      wr(`PSR_OFS_TX_CTRL, txB);
      selB = selB & `PSR_MASK_PATH_SEL;
      repeat (5) @(posedge clk);
      #1 chkPath();
      rd(`PSR_OFS_PATH_SEL, selB);
      rd(`PSR_OFS_TX_CTRL, txB);
    end
    // Both overrides on with the reserved code: modes must hold
    selB = 8'h55;
    wr(`PSR_OFS_PATH_SEL, selB);
    repeat (2) @(posedge clk);
    #1 chkPath();
    selB = 8'h00;
    wr(`PSR_OFS_PATH_SEL, selB);
    repeat (2) @(posedge clk);
    #1 chkPath();
    extSel = 2'b10;
    repeat (6) @(posedge clk);
    #1 chkPath();
    // Mid-run reset while the external code is still reserved
    sysRst = 1'b1;
    grpKind = 2'b00;
    txB = 8'h00;
    repeat (4) @(posedge clk);
    #1 sysRst = 1'b0;
    rxPrev = 2'b00;
    txPrev = 2'b00;
    chkPath();
    repeat (6) @(posedge clk);
    #1 chkPath();
    rd(`PSR_OFS_PATH_SEL, 8'h00);
    rd(`PSR_OFS_TX_CTRL, 8'h00);
    for (int k = 0; k < 9; k++) begin
      rwVal[k] = 8'(rnd());
      wr(rwOfs[k], rwVal[k]);
    end
    chk("seedB", {8'h00, rwVal[1], rwVal[0]}, {8'h00, seedB});
    chk("pmaControl", {16'h0000, rwVal[2]}, {16'h0000, pmaCtl});
    chk("loopback", {16'h0000, rwVal[3]}, {16'h0000, loopCtl});
    chk("stControl", {8'h00, rwVal[5], rwVal[4]}, {8'h00, stCtl});
    chk("const2", {rwVal[8], rwVal[7], rwVal[6]}, c2);
    for (int k = 0; k < 9; k++) rd(rwOfs[k], rwVal[k]);
    roVal = rnd();
    rd(`PSR_OFS_TP_CTRL0, roVal[7:0]);
    rd(`PSR_OFS_TP_CTRL1, roVal[15:8]);
    rd(`PSR_OFS_PMA_STAT, roVal[15:8]);
    rd(`PSR_OFS_ST_STAT0, ~roVal[7:0]);
    rd(`PSR_OFS_ST_STAT1, ~roVal[15:8]);
    errCnt = rnd();
    rd(`PSR_OFS_ERR_LO, errCnt[7:0]);
    rd(`PSR_OFS_ERR_HI, errCnt[15:8]);
    wr(`PSR_OFS_ERR_LO, ~errCnt[7:0]);
    rd(`PSR_OFS_ERR_LO, errCnt[7:0]);
    rd(8'h01, 8'h00);
    v = {8'(rnd()), rnd()};
    for (int k = 0; k < 3; k++) wr(`PSR_OFS_C1_B0 + 8'(k), v[8 * k +: 8]);
    chk("const1", v, c1);
    rd(`PSR_OFS_C1_MSB, v[23:16]);
    phyLevel = 4'(rnd());
    phyEvent = 4'h5;
    @(posedge clk);
    #1 phyEvent = 4'h0;
    rd(`PSR_OFS_PHY_STAT, {phyLevel, 4'h5});
    wr(`PSR_OFS_PHY_STAT, 8'hf1);
    rd(`PSR_OFS_PHY_STAT, {phyLevel, 4'h4});
    close_out();
  end
endmodule
